/* bench/acsl_axi_master.sv */
`timescale 1ns/1ps
module acsl_axi_master (
	input wire logic core_clk,
	output logic [4:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [4:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	// Ready is looked at mid-cycle; it only changes after an edge
	task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta;
		logic tw;
		logic tb;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge core_clk);
			ta = ta | s_axi_awready;
			tw = tw | s_axi_wready;
			@(posedge core_clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (ta) s_axi_awaddr <= ~a;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tw) s_axi_wdata <= ~d;
		end while (!(ta && tw));
		do begin
			@(negedge core_clk);
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge core_clk);
		end while (!tb);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		logic t;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge core_clk);
			t = s_axi_arready;
			@(posedge core_clk);
		end while (!t);
		s_axi_arvalid <= 1'b0;
		s_axi_araddr <= ~a;
		do begin
			@(negedge core_clk);
			t = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge core_clk);
		end while (!t);
		s_axi_rready <= 1'b0;
	endtask : rd
endmodule : acsl_axi_master

/* bench/acsl_checker.sv */
`timescale 1ns/1ps
module acsl_checker (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [23:0] first_data_bus,
	input wire logic [23:0] second_data_bus,
	input wire logic limit_flag
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	wire go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire clr = go && s_axi_awaddr == 5'h04 && s_axi_wdata[0];
	wire sx = first_data_bus == 24'h7FFFFF || first_data_bus == 24'h800000;
	wire sat = sx || second_data_bus == 24'h7FFFFF || second_data_bus == 24'h800000;
	a_flag_cause: assert property ($rose(limit_flag) |-> sat || $past(sat))
		else $error("limit flag rose without a saturated bus value");
	a_flag_sticky: assert property (limit_flag |=> limit_flag || $past(clr) || $past(clr, 2) || $past(clr, 3))
		else $error("limit flag dropped without a clear write");
	a_wr_okay: assert property (go && s_axi_awaddr <= 5'h10 |-> ##[1:3] s_axi_bvalid && s_axi_bresp == 2'h0)
		else $error("mapped write not answered okay");
	a_wr_refused: assert property (go && s_axi_awaddr > 5'h10 |-> ##[1:3] s_axi_bvalid && s_axi_bresp == 2'h2)
		else $error("unmapped write not refused");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write address taken while response pending");
	a_reset_out: assert property ($rose(reset_n) |-> !limit_flag && first_data_bus == 24'h0)
		else $error("outputs not cleared by reset");
endmodule : acsl_checker
bind acsl_top acsl_checker acsl_checker_i (.*);

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
	import acsl_pkg::*;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	int errors = 0;
	int cmp_count = 0;
	wire [4:0] s_axi_awaddr, s_axi_araddr;
	wire [31:0] s_axi_wdata, s_axi_rdata;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, limit_flag;
	wire [23:0] first_data_bus, second_data_bus;
	// Rounding cases: control word, upper, lower, expected upper
	logic [31:0] rc [7] = '{32'h68, 32'h68, 32'h68, 32'h1068, 32'h1068, 32'h468, 32'h868};
	logic [23:0] rh [7] = '{24'h2, 24'h3, 24'h2, 24'h2, 24'h2, 24'h3, 24'h1};
	logic [23:0] rl [7] = '{24'h800000, 24'h800000, 24'h800001, 24'h800000, 24'h7FFFFF, 24'h0, 24'hC00000};
	logic [23:0] re [7] = '{24'h2, 24'h4, 24'h3, 24'h3, 24'h2, 24'h4, 24'h2};
	acsl_top acsl_top_i (.*, .s_axi_wstrb(4'hF));
	acsl_axi_master acsl_axi_master_i (.*);
	initial begin
		forever #50 core_clk = ~core_clk;
	end
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
		logic [1:0] r;
		acsl_axi_master_i.wr(a, d, r);
		chk("bresp", 32'(r), 32'(e));
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
		logic [31:0] d;
		logic [1:0] r;
		acsl_axi_master_i.rd(a, d, r);
		chk("rdata", d, e);
		chk("rresp", 32'(r), 32'(er));
	endtask : rd
	task automatic op(input acsl_op_t o, input logic [5:0] sh = 6'h0, input logic [5:0] w = 6'h0);
		wr(5'h10, {10'h0, w, 2'h0, sh, 3'h0, o});
	endtask : op
	task automatic ld(input logic [23:0] hi, input logic [23:0] lo, input acsl_op_t o);
		wr(5'h08, 32'(hi));
		wr(5'h0C, 32'(lo));
		op(o);
	endtask : ld
	// Pins are registered, the flag on the same edge as the pins
	task automatic see(input logic [23:0] x, input logic [23:0] y, input logic f);
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		chk("first_data_bus", 32'(first_data_bus), 32'(x));
		chk("second_data_bus", 32'(second_data_bus), 32'(y));
		chk("limit_flag", 32'(limit_flag), 32'(f));
	endtask : see
	task automatic t_reset;
		see(24'h0, 24'h0, 1'b0);
		rd(5'h00, 32'h0);
		rd(5'h02, 32'h0, 2'h2);
	endtask : t_reset
	task automatic t_parts;
		ld(24'h800001, 24'h0, ACSL_OP_WR_WORD);
		wr(5'h00, 32'h64);
		see(24'hFFFFFF, 24'h0, 1'b0);
		wr(5'h0C, 32'h00ABCD);
		op(ACSL_OP_WR_LOWER);
		wr(5'h00, 32'h08);
		see(24'h800001, 24'h800001, 1'b0);
		wr(5'h00, 32'h64);
		see(24'hFFFFFF, 24'h00ABCD, 1'b0);
	endtask : t_parts
	task automatic t_round;
		for (int i = 0; i < 7; i++) begin
			wr(5'h00, rc[i]);
			ld(rh[i], rl[i], ACSL_OP_WR_LONG);
			op(ACSL_OP_ROUND);
			see(re[i], 24'h0, 1'b0);
		end
	endtask : t_round
	task automatic t_shift;
		wr(5'h00, 32'h68);
		ld(24'h800000, 24'h0, ACSL_OP_WR_WORD);
		op(ACSL_OP_ACC_DOUBLE_PRECISION_ACCUMULATE);
		see(24'hFFFFFF, 24'h800000, 1'b0);
		wr(5'h00, 32'h2068);
		ld(24'h123456, 24'h0, ACSL_OP_WR_WORD);
		op(ACSL_OP_ACC_DOUBLE_PRECISION_ACCUMULATE);
		see(24'h000012, 24'h345600, 1'b0);
		op(ACSL_OP_ACC_ZERO);
		see(24'h0, 24'h0, 1'b0);
		ld(24'h1, 24'h1, ACSL_OP_ADD_PROD);
		see(24'h2, 24'h2, 1'b0);
		wr(5'h00, 32'h68);
		ld(24'h800000, 24'h0, ACSL_OP_WR_WORD);
		op(ACSL_OP_ASR, 6'd4);
		see(24'hF80000, 24'h0, 1'b0);
		ld(24'h123456, 24'h0, ACSL_OP_WR_WORD);
		op(ACSL_OP_LSL, 6'd4);
		see(24'h234560, 24'h0, 1'b0);
	endtask : t_shift
	task automatic t_field;
		ld(24'h123456, 24'h0, ACSL_OP_WR_WORD);
		wr(5'h08, 32'h00FF00);
		op(ACSL_OP_AND);
		see(24'h003400, 24'h0, 1'b0);
		op(ACSL_OP_ROL);
		see(24'h006800, 24'h0, 1'b0);
		op(ACSL_OP_ROR);
		see(24'h003400, 24'h0, 1'b0);
		op(ACSL_OP_NOT);
		see(24'hFFCBFF, 24'h0, 1'b0);
		op(ACSL_OP_EOR);
		see(24'hFF34FF, 24'h0, 1'b0);
		op(ACSL_OP_OR);
		see(24'hFFFFFF, 24'h0, 1'b0);
		op(ACSL_OP_CLB);
		see(24'h0, 24'h000007, 1'b0);
		wr(5'h08, 32'hABCDEF);
		op(ACSL_OP_MERGE);
		see(24'hABCDEF, 24'h000007, 1'b0);
		op(ACSL_OP_LSR, 6'h04);
		see(24'h0ABCDE, 24'hF00000, 1'b0);
		op(ACSL_OP_UNSIGNED_FIELD_EXTRACT, 6'h18, 6'h08);
		see(24'h0, 24'h0000DE, 1'b0);
		wr(5'h08, 32'h80);
		op(ACSL_OP_WR_EXT);
		wr(5'h00, 32'h64);
		see(24'hFFFF80, 24'h0000DE, 1'b0);
		wr(5'h00, 32'h68);
		op(ACSL_OP_EXTRACT, 6'h00, 6'h08);
		see(24'hFFFFFF, 24'hFFFFDE, 1'b0);
		wr(5'h0C, 32'h5);
		op(ACSL_OP_INSERT, 6'h04, 6'h04);
		see(24'hFFFFFF, 24'hFFFF5E, 1'b0);
	endtask : t_field
	task automatic t_limit;
		ld(24'h400000, 24'h0, ACSL_OP_WR_WORD);
		wr(5'h00, 32'h840);
		see(24'h7FFFFF, 24'h400000, 1'b1);
		rd(5'h14, 32'h007FFFFF);
		wr(5'h00, 32'h440);
		see(24'h200000, 24'h400000, 1'b1);
		wr(5'h04, 32'h1);
		see(24'h200000, 24'h400000, 1'b0);
		wr(5'h00, 32'h100);
		ld(24'h100000, 24'h0, ACSL_OP_WR_WORD);
		wr(5'h00, 32'h0);
		ld(24'hBFFFFF, 24'h0, ACSL_OP_WR_WORD);
		wr(5'h00, 32'h802);
		see(24'h800000, 24'h200000, 1'b1);
		wr(5'h14, 32'h0, 2'h2);
		wr(5'h00, 32'h0);
		wr(5'h04, 32'h1);
	endtask : t_limit
	task automatic t_long;
		ld(24'h400000, 24'h123456, ACSL_OP_WR_LONG);
		wr(5'h00, 32'h10);
		see(24'h400000, 24'h123456, 1'b0);
		wr(5'h00, 32'h810);
		see(24'h7FFFFF, 24'hFFFFFF, 1'b1);
		ld(24'hA00000, 24'h0, ACSL_OP_WR_LONG);
		see(24'h800000, 24'h000000, 1'b1);
		wr(5'h00, 32'h04);
		see(24'hFFFFFF, 24'hA00000, 1'b1);
		rd(5'h10, 32'h00A00000);
		rd(5'h1C, 32'h00FF0000);
		rd(5'h18, 32'h00A00000);
		rd(5'h04, 32'h00000001);
	endtask : t_long
	task automatic stop_test;
		$display("Comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_reset();
		t_parts();
		t_round();
		t_shift();
		t_field();
		t_limit();
		t_long();
		stop_test();
	end
	// Whole run needs well under a tenth of this span
	initial begin
		#2000000;
		errors++;
		stop_test();
	end
endmodule : testbench

/* core/acsl_cfg.svh */
`ifndef ACSL_CFG_SVH
`define ACSL_CFG_SVH
`define ACSL_ADDR_CTRL 5'h00
`define ACSL_ADDR_STATUS 5'h04
`define ACSL_ADDR_WDATA_HI 5'h08
`define ACSL_ADDR_WDATA_LO 5'h0C
`define ACSL_ADDR_CMD 5'h10
`define ACSL_ADDR_RD_X 5'h14
`define ACSL_ADDR_RD_Y 5'h18
`define ACSL_ADDR_ACC_EXT 5'h1C
`define ACSL_CTRL_SCALE_LO 10
`define ACSL_CTRL_SCALE_HI 11
`define ACSL_CTRL_ROUND_TYPE 12
`define ACSL_CTRL_SIXTEEN 13
`define ACSL_CTRL_RESET 32'h00000000
`define ACSL_SAT24_POS 24'h7FFFFF
`define ACSL_SAT24_NEG 24'h800000
`define ACSL_SAT48_POS 48'h7FFFFFFFFFFF
`define ACSL_SAT48_NEG 48'h800000000000
`define ACSL_RESP_OKAY 2'h0
`define ACSL_RESP_SLVERR 2'h2
`endif

/* core/acsl_pkg.sv */
package acsl_pkg;
	typedef enum logic [1:0] {ACSL_SCALE_NONE, ACSL_SCALE_DOWN, ACSL_SCALE_UP, ACSL_SCALE_RSVD} acsl_scale_t;
	typedef enum logic [2:0] {ACSL_SRC_ACC, ACSL_SRC_EXT, ACSL_SRC_UPPER, ACSL_SRC_LOWER, ACSL_SRC_LONG}
		acsl_src_t;
	typedef enum logic [4:0] {
		ACSL_OP_NOP, ACSL_OP_WR_WORD, ACSL_OP_WR_LONG, ACSL_OP_WR_UPPER, ACSL_OP_WR_LOWER,
		ACSL_OP_WR_EXT, ACSL_OP_ACC_ZERO, ACSL_OP_ACC_DOUBLE_PRECISION_ACCUMULATE, ACSL_OP_ROUND, ACSL_OP_ASL, ACSL_OP_ASR,
		ACSL_OP_LSL, ACSL_OP_LSR, ACSL_OP_ROL, ACSL_OP_ROR, ACSL_OP_AND, ACSL_OP_OR, ACSL_OP_EOR,
		ACSL_OP_NOT, ACSL_OP_CLB, ACSL_OP_FAST_NORMALIZE, ACSL_OP_MERGE, ACSL_OP_INSERT, ACSL_OP_EXTRACT,
		ACSL_OP_UNSIGNED_FIELD_EXTRACT, ACSL_OP_ADD_PROD
	} acsl_op_t;
endpackage : acsl_pkg

/* core/acsl_top.sv */
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "acsl_cfg.svh"
// Summary of operation
// - Accumulator is extension, upper, lower words.
// - Overflowed accumulator reads give limit constant.
// - Scale first, then detect overflow, limit.
// - Only whole accumulator reads scale and limit.
// - Extension byte reads sign-extend to 24.
// - Word write: upper, lower zero, sign extension.
// - Long write loads both, sign-extends extension.
// - Part writes touch only that part.
// - Pre-accumulate shifter: pass, >>24, >>16, zero.
// - Bit unit shifts and one-bit rotates.
// - Bit unit fields, leading bits, normalize, logic.
// - Two independent read shifter-limiters, one per bus.
// - Scale up, down or none from bits 11:10.
// - Shifter gives 24-bit word plus overflow.
// - Long reads combine limiters into 48 bits.
// - Fits passes; else same-sign maximum magnitude.
// - Constants 7FFFFF/800000 and 48-bit pairs.
// - Limiting sets a sticky limit flag.
// - Rounding boundary set by scaling bits.
// - Round type bit; convergent by default.
// - Convergent: exact half rounds to even.
// - Scaling moves round point, not contents.
// - Products left-aligned with zero LSB.
// - Two's complement: half and above round up.
module acsl_top (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [23:0] first_data_bus,
	output logic [23:0] second_data_bus,
	output logic limit_flag
);
	import acsl_pkg::*;

	logic rst_meta, rst_sync, rst_n;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end
	assign rst_n = rst_sync;

	// Accumulators A (0) and B (1), each three parts
	logic [7:0] extension_byte [2];
	logic [23:0] upper_word [2];
	logic [23:0] lower_word [2];
	logic [31:0] ctrl, wdata_hi, wdata_lo;
	logic [31:0] result_stat;

	logic [1:0] scale;
	logic round_type_select, sixteen_bit_arith_mode;
	assign scale = {ctrl[`ACSL_CTRL_SCALE_HI], ctrl[`ACSL_CTRL_SCALE_LO]};
	assign round_type_select = ctrl[`ACSL_CTRL_ROUND_TYPE];
	assign sixteen_bit_arith_mode = ctrl[`ACSL_CTRL_SIXTEEN];

	// Read path: x bus uses source accumulator ctrl[0], y bus ctrl[1]
	function automatic logic [55:0] acc_of(input logic [7:0] e, input logic [23:0] u, input logic [23:0] l);
		acc_of = {e, u, l};
	endfunction

	function automatic logic [55:0] scaled(input logic [55:0] v, input logic [1:0] s);
		case (s)
			2'b01: scaled = {v[55], v[55:1]};
			2'b10: scaled = {v[54:0], 1'b0};
			default: scaled = v;
		endcase
	endfunction

	logic [55:0] acc_x, acc_y, sh_x, sh_y;
	logic ovf_x, ovf_y, lim_x, lim_y;
	logic [23:0] out_x, out_y;
	acsl_src_t src_x, src_y;
	assign src_x = acsl_src_t'(ctrl[4:2]);
	assign src_y = acsl_src_t'(ctrl[7:5]);
	assign acc_x = acc_of(extension_byte[ctrl[0]], upper_word[ctrl[0]], lower_word[ctrl[0]]);
	assign acc_y = acc_of(extension_byte[ctrl[1]], upper_word[ctrl[1]], lower_word[ctrl[1]]);
	assign sh_x = scaled(acc_x, scale);
	assign sh_y = scaled(acc_y, scale);
	// Overflow when sign bit 47 not replicated through extension
	assign ovf_x = (sh_x[55:47] != {9{sh_x[55]}});
	assign ovf_y = (sh_y[55:47] != {9{sh_y[55]}});

	// Per-bus read mux; long reads put upper on x and lower on y as one 48-bit limiter
	always_comb begin
		out_x = sh_x[47:24];
		out_y = sh_y[47:24];
		lim_x = 1'b0;
		lim_y = 1'b0;
		if (src_x == ACSL_SRC_LONG) begin
			out_y = sh_x[23:0];
			if (ovf_x) begin
				out_x = sh_x[55] ? 24'(`ACSL_SAT48_NEG >> 24) : 24'(`ACSL_SAT48_POS >> 24);
				out_y = sh_x[55] ? 24'(`ACSL_SAT48_NEG) : 24'(`ACSL_SAT48_POS);
				lim_x = 1'b1;
			end
		end else begin
			case (src_x)
				ACSL_SRC_ACC: if (ovf_x) begin
					out_x = sh_x[55] ? `ACSL_SAT24_NEG : `ACSL_SAT24_POS;
					lim_x = 1'b1;
				end
				ACSL_SRC_EXT: out_x = {{16{acc_x[55]}}, acc_x[55:48]};
				ACSL_SRC_UPPER: out_x = acc_x[47:24];
				ACSL_SRC_LOWER: out_x = acc_x[23:0];
				default: out_x = sh_x[47:24];
			endcase
			case (src_y)
				ACSL_SRC_ACC: if (ovf_y) begin
					out_y = sh_y[55] ? `ACSL_SAT24_NEG : `ACSL_SAT24_POS;
					lim_y = 1'b1;
				end
				ACSL_SRC_EXT: out_y = {{16{acc_y[55]}}, acc_y[55:48]};
				ACSL_SRC_UPPER: out_y = acc_y[47:24];
				ACSL_SRC_LOWER: out_y = acc_y[23:0];
				default: out_y = sh_y[47:24];
			endcase
		end
	end
	// Bus outputs registered from read-path result
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			first_data_bus <= 24'h000000;
			second_data_bus <= 24'h000000;
		end else begin
			first_data_bus <= out_x;
			second_data_bus <= out_y;
		end
	end

	// Command engine on accumulator ctrl[8]
	logic cmd_go;
	acsl_op_t cmd_op;
	logic [5:0] cmd_amt, cmd_wid;
	logic [55:0] acc_c, res;
	logic dst;
	assign dst = ctrl[8];
	assign acc_c = acc_of(extension_byte[dst], upper_word[dst], lower_word[dst]);

	function automatic logic [5:0] lead_bits(input logic [55:0] v);
		logic [5:0] n;
		n = 6'h00;
		for (int i = 54; i >= 0; i--) begin
			if (v[i] != v[55]) break;
			n = n + 6'h01;
		end
		lead_bits = n;
	endfunction

	logic [55:0] mask, fld, rnd_add, rnd_mask;
	logic [5:0] lb;
	logic half, keep_lsb;
	always_comb begin
		mask = ~(56'hFFFFFFFFFFFFFF << cmd_wid) << cmd_amt;
		fld = (acc_c >> cmd_amt) & ~(56'hFFFFFFFFFFFFFF << cmd_wid);
		lb = lead_bits(acc_c);
		// Round point follows scaling: bit 23, 22 or 24
		case (scale)
			2'b01: rnd_add = 56'h00000001000000;
			2'b10: rnd_add = 56'h00000000400000;
			default: rnd_add = 56'h00000000800000;
		endcase
		rnd_mask = (rnd_add << 1) - 56'h1;
		half = ((acc_c & rnd_mask) == rnd_add);
		keep_lsb = |(acc_c & (rnd_add << 1));
		res = acc_c;
		case (cmd_op)
			ACSL_OP_ACC_ZERO: res = 56'h0;
			ACSL_OP_ACC_DOUBLE_PRECISION_ACCUMULATE: res = sixteen_bit_arith_mode ? 56'($signed(acc_c) >>> 16)
				: 56'($signed(acc_c) >>> 24);
			ACSL_OP_ADD_PROD: res = acc_c + {{8{wdata_hi[23]}}, wdata_hi[22:0], wdata_lo[23:0], 1'b0};
			ACSL_OP_ROUND: begin
				if (round_type_select || !half)
					res = (acc_c + rnd_add) & ~rnd_mask;
				else
					res = keep_lsb ? (acc_c + rnd_add) & ~rnd_mask : acc_c & ~rnd_mask;
			end
			ACSL_OP_ASL: res = acc_c << cmd_amt;
			ACSL_OP_LSL: res = {acc_c[55:48], acc_c[47:0] << cmd_amt};
			ACSL_OP_ASR: res = 56'($signed(acc_c) >>> cmd_amt);
			ACSL_OP_LSR: res = {acc_c[55:48], acc_c[47:0] >> cmd_amt};
			ACSL_OP_ROL: res = {acc_c[55:48], acc_c[46:24], acc_c[47], acc_c[23:0]};
			ACSL_OP_ROR: res = {acc_c[55:48], acc_c[24], acc_c[47:25], acc_c[23:0]};
			ACSL_OP_AND: res = {acc_c[55:48], acc_c[47:24] & wdata_hi[23:0], acc_c[23:0]};
			ACSL_OP_OR: res = {acc_c[55:48], acc_c[47:24] | wdata_hi[23:0], acc_c[23:0]};
			ACSL_OP_EOR: res = {acc_c[55:48], acc_c[47:24] ^ wdata_hi[23:0], acc_c[23:0]};
			ACSL_OP_NOT: res = {acc_c[55:48], ~acc_c[47:24], acc_c[23:0]};
			ACSL_OP_CLB: res = {32'h0, 18'h0, lb};
			ACSL_OP_FAST_NORMALIZE: res = (lb > 6'h08) ? acc_c << (lb - 6'h08) : 56'($signed(acc_c) >>> (6'h08 - lb));
			ACSL_OP_MERGE: res = {acc_c[55:48], wdata_hi[23:0], acc_c[23:0]};
			ACSL_OP_INSERT: res = (acc_c & ~mask) | (({24'h0, wdata_lo} << cmd_amt) & mask);
			ACSL_OP_EXTRACT: res = 56'($signed(fld << (56 - cmd_wid)) >>> (56 - cmd_wid));
			ACSL_OP_UNSIGNED_FIELD_EXTRACT: res = fld;
			default: res = acc_c;
		endcase
	end

	// Accumulator writes, one clocked process for storage
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 2; i++) begin
				extension_byte[i] <= 8'h00;
				upper_word[i] <= 24'h000000;
				lower_word[i] <= 24'h000000;
			end
		end else if (cmd_go) begin
			case (cmd_op)
				ACSL_OP_NOP: ;
				ACSL_OP_WR_WORD: begin
					upper_word[dst] <= wdata_hi[23:0];
					lower_word[dst] <= 24'h000000;
					extension_byte[dst] <= {8{wdata_hi[23]}};
				end
				ACSL_OP_WR_LONG: begin
					upper_word[dst] <= wdata_hi[23:0];
					lower_word[dst] <= wdata_lo[23:0];
					extension_byte[dst] <= {8{wdata_hi[23]}};
				end
				ACSL_OP_WR_UPPER: upper_word[dst] <= wdata_hi[23:0];
				ACSL_OP_WR_LOWER: lower_word[dst] <= wdata_lo[23:0];
				ACSL_OP_WR_EXT: extension_byte[dst] <= wdata_hi[7:0];
				default: begin
					extension_byte[dst] <= res[55:48];
					upper_word[dst] <= res[47:24];
					lower_word[dst] <= res[23:0];
				end
			endcase
		end
	end

	// Limit flag latches until software clears it; a new limit wins over the clear
	logic stat_clr;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			limit_flag <= 1'b0;
		else if (lim_x || lim_y)
			limit_flag <= 1'b1;
		else if (stat_clr)
			limit_flag <= 1'b0;
	end

	// AXI4-Lite slave
	logic aw_held, w_held;
	logic [4:0] aw_addr;
	logic [31:0] w_data;
	logic do_write;
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign stat_clr = do_write && (aw_addr == `ACSL_ADDR_STATUS) && w_data[0];
	assign cmd_go = do_write && (aw_addr == `ACSL_ADDR_CMD);
	assign cmd_op = acsl_op_t'(w_data[4:0]);
	assign cmd_amt = w_data[13:8];
	assign cmd_wid = w_data[21:16];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 5'h00;
			w_data <= 32'h00000000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ACSL_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr > `ACSL_ADDR_CMD) ? `ACSL_RESP_SLVERR : `ACSL_RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= `ACSL_CTRL_RESET;
			wdata_hi <= 32'h00000000;
			wdata_lo <= 32'h00000000;
		end else if (do_write) begin
			case (aw_addr)
				`ACSL_ADDR_CTRL: ctrl <= w_data;
				`ACSL_ADDR_WDATA_HI: wdata_hi <= w_data;
				`ACSL_ADDR_WDATA_LO: wdata_lo <= w_data;
				default: ;
			endcase
		end
	end

	assign result_stat = {31'h0, limit_flag};
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `ACSL_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `ACSL_RESP_OKAY;
			case (s_axi_araddr)
				`ACSL_ADDR_CTRL: s_axi_rdata <= ctrl;
				`ACSL_ADDR_STATUS: s_axi_rdata <= result_stat;
				`ACSL_ADDR_WDATA_HI: s_axi_rdata <= wdata_hi;
				`ACSL_ADDR_WDATA_LO: s_axi_rdata <= wdata_lo;
				`ACSL_ADDR_CMD: s_axi_rdata <= {8'h0, upper_word[dst]};
				`ACSL_ADDR_RD_X: s_axi_rdata <= {8'h0, first_data_bus};
				`ACSL_ADDR_RD_Y: s_axi_rdata <= {8'h0, second_data_bus};
				`ACSL_ADDR_ACC_EXT: s_axi_rdata <= {8'h0, extension_byte[dst], lower_word[dst][15:0]};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `ACSL_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : acsl_top
